// >>> design/dtw_step_lookup.sv
// window time step, in base ticks, from data rate, power mode, filter and hybrid setting
`timescale 1ns/10ps
`include "dtw_defines.svh"

module dtw_step_lookup
	import dtw_pkg::*;
(
	input wire logic [2:0] odrSel,
	input wire dtw_power_mode_t powerMode,
	input wire logic hpfEnable,
	input wire logic hybridMode,
	output logic [`DTW_STEP_W-1:0] stepUnits
);

	// ----------------------------------------
	// exponent per power mode, filter on
	// ----------------------------------------
	wire logic [3:0] odrPlusOne = {1'b0, odrSel} + `DTW_EXP_ONE;
	wire logic slowRate = odrSel > `DTW_ODR_50;
	wire logic [3:0] normalExp = slowRate ? `DTW_EXP_NORMAL_SAT : odrPlusOne;
	wire logic [3:0] lowNoiseExp = slowRate ? `DTW_EXP_SLOW_SAT : odrPlusOne;
	wire logic [3:0] hiresExp = (odrSel == `DTW_ODR_800) ? `DTW_EXP_ONE : `DTW_EXP_HIRES;
	wire logic [3:0] lowPowerExp = (odrSel == `DTW_ODR_12P5) ? `DTW_EXP_SLOW_SAT :
		(odrSel > `DTW_ODR_12P5) ? `DTW_EXP_LP_SAT : odrPlusOne;
	wire logic [3:0] modeExp = (powerMode == PM_NORMAL) ? normalExp :
		(powerMode == PM_LOW_NOISE_LOW_POWER) ? lowNoiseExp :
		(powerMode == PM_HIRES) ? hiresExp : lowPowerExp;

	// filter off halves the step, hybrid doubles it
	wire logic [3:0] finalExp = modeExp - {3'h0, ~hpfEnable} + {3'h0, hybridMode};

	assign stepUnits = `DTW_STEP_W'(1) << finalExp;

endmodule // dtw_step_lookup

// >>> design/dtw_step_prescaler.sv
// divides the base tick down to one window time step
`timescale 1ns/10ps
`include "dtw_defines.svh"

module dtw_step_prescaler
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic restart,
	input wire logic baseTick,
	input wire logic [`DTW_STEP_W-1:0] stepUnits,
	output logic stepTick
);

	logic [`DTW_STEP_W-1:0] count_reg;
	wire logic [`DTW_STEP_W-1:0] countInc = count_reg + `DTW_STEP_W'(1);
	wire logic stepDone = baseTick && (countInc == stepUnits);

	// restart aligns the first step to the moment the window opens
	always_ff @(posedge mclk)
	begin
		if (sys_rst || restart)
		begin
			count_reg <= '0;
			stepTick <= 1'b0;
		end
		else
		begin
			count_reg <= stepDone ? '0 : (baseTick ? countInc : count_reg);
			stepTick <= stepDone;
		end
	end

endmodule // dtw_step_prescaler

// >>> design/dtw_window_timer.sv
// double-tap second-pulse window timer with apb register slave
`timescale 1ns/10ps
`include "dtw_defines.svh"

module dtw_window_timer
	import dtw_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`DTW_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic baseTick,
	input wire logic firstPulse,
	input wire logic latencyDone,
	input wire logic pulseAbove,
	input wire logic limitTick,
	input wire logic [7:0] pulseTimeLimit,
	output logic doublePulse,
	output logic windowOpen,
	output logic irq
);

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic [7:0] pulse_second_window_reg;
	logic [7:0] primary_control_config_reg;
	logic [`DTW_EV_W-1:0] eventStatus_reg;
	logic [`DTW_EV_W-1:0] eventMask_reg;

	// ----------------------------------------
	// timer state
	// ----------------------------------------
	dtw_state_t state_reg;
	dtw_state_t state_next;
	logic [7:0] windowCount_reg;
	logic [7:0] windowCount_next;
	logic [7:0] widthCount_reg;
	logic [7:0] widthCount_next;
	logic pulseAbove_reg;
	logic doublePulse_next;
	logic windowOpen_next;
	logic [`DTW_EV_W-1:0] events;
	logic stepTick;
	logic [`DTW_STEP_W-1:0] stepUnits;

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire logic setupPhase = psel && !penable;
	wire logic accessPhase = psel && penable;
	wire logic hitWindow = paddr == `DTW_OFF_WINDOW;
	wire logic hitConfig = paddr == `DTW_OFF_CONFIG;
	wire logic hitStatus = paddr == `DTW_OFF_STATUS;
	wire logic hitMask = paddr == `DTW_OFF_MASK;
	wire logic hitState = paddr == `DTW_OFF_STATE;
	wire logic hitAny = hitWindow || hitConfig || hitStatus || hitMask || hitState;
	wire logic writeWindow = accessPhase && pwrite && hitWindow;
	wire logic writeConfig = accessPhase && pwrite && hitConfig;
	wire logic writeMask = accessPhase && pwrite && hitMask;
	wire logic readStatus = accessPhase && !pwrite && hitStatus;

	// single-cycle access: data is staged during setup so no wait states are needed
	assign pready = 1'b1;
	assign pslverr = accessPhase && !hitAny;

	wire logic [31:0] readMux =
		hitWindow ? {24'h000000, pulse_second_window_reg} :
		hitConfig ? {24'h000000, primary_control_config_reg} :
		hitStatus ? {29'h0, eventStatus_reg} :
		hitMask ? {29'h0, eventMask_reg} :
		hitState ? {12'h000, widthCount_reg, windowCount_reg, state_reg} :
		32'h00000000;

	// ----------------------------------------
	// configuration fields
	// ----------------------------------------
	wire logic doubleEnable = primary_control_config_reg[`DTW_CFG_DOUBLE];
	wire logic [2:0] odrSel =
		primary_control_config_reg[`DTW_CFG_ODR_MSB:`DTW_CFG_ODR_LSB];
	wire dtw_power_mode_t powerMode =
		dtw_power_mode_t'(primary_control_config_reg[`DTW_CFG_MODE_MSB:`DTW_CFG_MODE_LSB]);
	wire logic hpfEnable = primary_control_config_reg[`DTW_CFG_HPF];
	wire logic hybridMode = primary_control_config_reg[`DTW_CFG_HYBRID];

	// ----------------------------------------
	// step generation
	// ----------------------------------------
	dtw_step_lookup stepTable
	(
		.odrSel(odrSel),
		.powerMode(powerMode),
		.hpfEnable(hpfEnable),
		.hybridMode(hybridMode),
		.stepUnits(stepUnits)
	);

	// the window step restarts with the window so the first step is whole
	wire logic windowStart = (state_reg == ST_LATENCY) && latencyDone;

	dtw_step_prescaler stepDivider
	(
		.mclk(mclk),
		.sys_rst(sys_rst),
		.restart(windowStart),
		.baseTick(baseTick),
		.stepUnits(stepUnits),
		.stepTick(stepTick)
	);

	// ----------------------------------------
	// pulse edges
	// ----------------------------------------
	wire logic secondStart = pulseAbove && !pulseAbove_reg;
	wire logic secondEnd = !pulseAbove && pulseAbove_reg;
	wire logic [7:0] widthInc = widthCount_reg + 8'h01;
	wire logic widthOver = limitTick && (widthInc >= pulseTimeLimit);
	wire logic lastStep = stepTick && (windowCount_reg == 8'h01);

	// ----------------------------------------
	// window state machine
	// ----------------------------------------
	always_comb
	begin
		state_next = state_reg;
		windowCount_next = windowCount_reg;
		widthCount_next = widthCount_reg;
		doublePulse_next = 1'b0;
		events = `DTW_EVENT_RST;
		case (state_reg)
			ST_IDLE:
			begin
				if (firstPulse && doubleEnable)
				begin
					state_next = ST_LATENCY;
				end
			end
			ST_LATENCY:
			begin
				if (!doubleEnable)
				begin
					state_next = ST_IDLE;
				end
				else if (latencyDone)
				begin
					// full 8-bit count, at most 255 steps
					windowCount_next = pulse_second_window_reg;
					if (pulse_second_window_reg == `DTW_COUNT_RST)
					begin
						// a zero window closes at once
						state_next = ST_IDLE;
						events[`DTW_EV_EXPIRED] = 1'b1;
					end
					else
					begin
						state_next = ST_WINDOW;
					end
				end
			end
			ST_WINDOW:
			begin
				if (!doubleEnable)
				begin
					state_next = ST_IDLE;
					windowCount_next = `DTW_COUNT_RST;
				end
				else if (secondStart)
				begin
					// a start in the expiry cycle still counts as inside
					state_next = ST_WIDTH;
					widthCount_next = `DTW_COUNT_RST;
					windowCount_next = `DTW_COUNT_RST;
				end
				else if (lastStep)
				begin
					state_next = ST_IDLE;
					windowCount_next = `DTW_COUNT_RST;
					events[`DTW_EV_EXPIRED] = 1'b1;
				end
				else if (stepTick)
				begin
					// one count per effective step
					windowCount_next = windowCount_reg - 8'h01;
				end
			end
			ST_WIDTH:
			begin
				// window expiry no longer matters here
				if (!doubleEnable)
				begin
					state_next = ST_IDLE;
				end
				else if (secondEnd)
				begin
					state_next = ST_IDLE;
					if (widthCount_reg < pulseTimeLimit)
					begin
						// width below the limit
						doublePulse_next = 1'b1;
						events[`DTW_EV_DOUBLE] = 1'b1;
					end
					else
					begin
						events[`DTW_EV_REJECTED] = 1'b1;
					end
				end
				else if (widthOver)
				begin
					// too wide, give up before the pulse ends
					state_next = ST_IDLE;
					events[`DTW_EV_REJECTED] = 1'b1;
				end
				else if (limitTick)
				begin
					widthCount_next = widthInc;
				end
			end
			default:
			begin
				state_next = ST_IDLE;
				windowCount_next = `DTW_COUNT_RST;
				widthCount_next = `DTW_COUNT_RST;
			end
		endcase
	end

	assign windowOpen_next = state_next == ST_WINDOW;

	// ----------------------------------------
	// state registers
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			state_reg <= ST_IDLE;
			windowCount_reg <= `DTW_COUNT_RST;
			widthCount_reg <= `DTW_COUNT_RST;
			pulseAbove_reg <= 1'b0;
			doublePulse <= 1'b0;
			windowOpen <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			windowCount_reg <= windowCount_next;
			widthCount_reg <= widthCount_next;
			pulseAbove_reg <= pulseAbove;
			doublePulse <= doublePulse_next;
			windowOpen <= windowOpen_next;
		end
	end

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			pulse_second_window_reg <= `DTW_WINDOW_RST;
			primary_control_config_reg <= `DTW_CONFIG_RST;
			eventMask_reg <= `DTW_EVENT_RST;
		end
		else
		begin
			if (writeWindow)
			begin
				pulse_second_window_reg <= pwdata[7:0];
			end
			if (writeConfig)
			begin
				primary_control_config_reg <= pwdata[7:0];
			end
			if (writeMask)
			begin
				eventMask_reg <= pwdata[`DTW_EV_W-1:0];
			end
		end
	end

	// read data is staged in setup so it is stable for the whole access phase
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			prdata <= 32'h00000000;
		end
		else if (setupPhase)
		begin
			prdata <= pwrite ? 32'h00000000 : readMux;
		end
	end

	// ----------------------------------------
	// sticky events, cleared by reading them
	// ----------------------------------------
	genvar evIdx;
	generate
		for (evIdx = 0; evIdx < `DTW_EV_W; evIdx = evIdx + 1)
		begin : gStickyEvent
			// a read clears only the bits it returned, so an event set after setup is not lost
			always_ff @(posedge mclk)
			begin
				if (sys_rst)
				begin
					eventStatus_reg[evIdx] <= 1'b0;
				end
				else if (events[evIdx])
				begin
					eventStatus_reg[evIdx] <= 1'b1;
				end
				else if (readStatus && prdata[evIdx])
				begin
					eventStatus_reg[evIdx] <= 1'b0;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// interrupt
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			irq <= 1'b0;
		end
		else
		begin
			irq <= |(eventStatus_reg & eventMask_reg);
		end
	end

endmodule // dtw_window_timer

// >>> pkg/dtw_defines.svh
// register map, field positions, reset values and step-table figures of the window timer
`ifndef DTW_DEFINES_SVH
`define DTW_DEFINES_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define DTW_ADDR_W 8
`define DTW_OFF_WINDOW 8'h28
`define DTW_OFF_CONFIG 8'h2C
`define DTW_OFF_STATUS 8'h30
`define DTW_OFF_MASK 8'h34
`define DTW_OFF_STATE 8'h38

// ----------------------------------------
// reset values
// ----------------------------------------
`define DTW_WINDOW_RST 8'h00
`define DTW_CONFIG_RST 8'h00
`define DTW_EVENT_RST 3'h0
`define DTW_COUNT_RST 8'h00

// ----------------------------------------
// configuration fields
// ----------------------------------------
`define DTW_CFG_DOUBLE 0
`define DTW_CFG_ODR_LSB 1
`define DTW_CFG_ODR_MSB 3
`define DTW_CFG_MODE_LSB 4
`define DTW_CFG_MODE_MSB 5
`define DTW_CFG_HPF 6
`define DTW_CFG_HYBRID 7

// ----------------------------------------
// event bits
// ----------------------------------------
`define DTW_EV_DOUBLE 0
`define DTW_EV_EXPIRED 1
`define DTW_EV_REJECTED 2
`define DTW_EV_W 3

// ----------------------------------------
// step table, in 1.25 ms base ticks, as powers of two
// ----------------------------------------
`define DTW_STEP_W 10
`define DTW_ODR_800 3'h0
`define DTW_ODR_50 3'h4
`define DTW_ODR_12P5 3'h5
`define DTW_EXP_ONE 4'h1
`define DTW_EXP_NORMAL_SAT 4'h5
`define DTW_EXP_HIRES 4'h2
`define DTW_EXP_SLOW_SAT 4'h7
`define DTW_EXP_LP_SAT 4'h8

`endif

// >>> pkg/dtw_pkg.sv
// types shared by the double-tap window timer
package dtw_pkg;

	typedef enum logic [3:0]
	{
		ST_IDLE = 4'h1,
		ST_LATENCY = 4'h2,
		ST_WINDOW = 4'h4,
		ST_WIDTH = 4'h8
	} dtw_state_t;

	typedef enum logic [1:0]
	{
		PM_NORMAL = 2'h0,
		PM_LOW_NOISE_LOW_POWER = 2'h1,
		PM_HIRES = 2'h2,
		PM_LOW_POWER = 2'h3
	} dtw_power_mode_t;

endpackage

// >>> sim/dtw_window_timer_sva.sv
// assertion checker for the window timer
`timescale 1ns/10ps
`include "dtw_defines.svh"
module dtw_window_timer_chk
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`DTW_ADDR_W-1:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic latencyDone,
	input wire logic pulseAbove,
	input wire logic doublePulse,
	input wire logic windowOpen,
	input wire logic irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// ----
	// checks
	// ----
	wire mapped = paddr inside {8'h28, 8'h2C, 8'h30, 8'h34, 8'h38};
	wire stRead = psel && penable && !pwrite && paddr == `DTW_OFF_STATUS;
	ready_always_a: assert property (pready)
		else $error("pready low");
	unmapped_err_a: assert property (psel && penable |-> pslverr == !mapped)
		else $error("pslverr wrong");
	open_cause_a: assert property ($rose(windowOpen) |-> $past(latencyDone))
		else $error("window opened without latency end");
	start_closes_a: assert property (windowOpen && $rose(pulseAbove) |=> !windowOpen)
		else $error("window stayed open after start");
	pulse_end_a: assert property (doublePulse |-> $past(pulseAbove, 2) && !$past(pulseAbove))
		else $error("double pulse not at pulse end");
	pulse_once_a: assert property (doublePulse |=> !doublePulse)
		else $error("double pulse too long");
	closed_double_a: assert property (doublePulse |-> !windowOpen)
		else $error("window open at double pulse");
	rst_idle_a: assert property ($fell(sys_rst) |-> !windowOpen && !irq && !doublePulse)
		else $error("outputs active after reset");
	// quiet read: no event in setup or access cycle can set status, so the line must drop
	irq_clear_a: assert property (stRead && !windowOpen && !pulseAbove
		&& !doublePulse && !latencyDone && !$past(windowOpen) && !$past(pulseAbove)
		&& !$past(pulseAbove, 2) && !$past(latencyDone) |-> ##2 !irq)
		else $error("irq stuck after status read");
	cover property ($fell(windowOpen));
	cover property (doublePulse);
	cover property (irq);
	cover property (psel && penable && pslverr);
endmodule // dtw_window_timer_chk

bind dtw_window_timer dtw_window_timer_chk u_chk (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.latencyDone(latencyDone), .pulseAbove(pulseAbove), .doublePulse(doublePulse),
	.windowOpen(windowOpen), .irq(irq));

// >>> sim/tb_double_tap_window_timer.sv
// self-checking bench for the window timer
`timescale 1ns/10ps
`include "dtw_defines.svh"
module tb_double_tap_window_timer;
	logic mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, pulseTimeLimit = 8'h00;
	logic [31:0] pwdata = 32'h0, rd;
	logic baseTick = 1'b0, firstPulse = 1'b0, latencyDone = 1'b0, pulseAbove = 1'b0;
	logic limitTick = 1'b0;
	logic [2:0] phase = 3'h0, maskVal = 3'h7;
	wire [31:0] prdata;
	wire pready, pslverr, doublePulse, windowOpen, irq;
	int err_count = 0, check_count = 0, cycles = 0, dpCount = 0, ticks;
	logic [7:0] addrs [6] = '{8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C};
	logic [31:0] exps [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0};
	dtw_window_timer u_dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .baseTick(baseTick), .firstPulse(firstPulse),
		.latencyDone(latencyDone), .pulseAbove(pulseAbove), .limitTick(limitTick),
		.pulseTimeLimit(pulseTimeLimit), .doublePulse(doublePulse), .windowOpen(windowOpen),
		.irq(irq));
	initial forever #2.5 mclk = ~mclk;
	// ----
	// timebase, monitor, watchdog
	// ----
	// ticks every 8 cycles so a close a few cycles late never swallows one
	always @(posedge mclk)
	begin
		phase <= phase + 3'h1;
		baseTick <= (phase == 3'h6);
		cycles++;
		if (doublePulse === 1'b1) dpCount++;
		if (cycles == 60000)
		begin
			err_count++;
			end_of_test();
		end
	end
	task end_of_test();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// ----
	// apb master
	// ----
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic es);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		chk("pslverr", {31'h0, pslverr}, {31'h0, es});
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task rdChk(input logic [7:0] a, input logic [31:0] exp, input logic es);
		apb(1'b0, a, 32'h0, es);
		chk("prdata", rd, exp);
	endtask
	// ----
	// detector sequences
	// ----
	function automatic int stepFor(int r, int m, int hpf, int hyb);
		int e;
		case (m)
			0: e = r < 4 ? r + 1 : 5;
			1: e = r < 5 ? r + 1 : 7;
			2: e = r == 0 ? 1 : 2;
			default: e = r < 5 ? r + 1 : (r == 5 ? 7 : 8);
		endcase
		return 1 << (e - 1 + hpf + hyb);
	endfunction
	task openWin();
		firstPulse <= 1'b1;
		@(posedge mclk);
		firstPulse <= 1'b0;
		do @(posedge mclk); while (baseTick !== 1'b1);
		latencyDone <= 1'b1;
		@(posedge mclk);
		latencyDone <= 1'b0;
	endtask
	task doWin(input logic [7:0] cfg, input logic [7:0] cnt, input int exp);
		logic seen;
		apb(1'b1, `DTW_OFF_CONFIG, {24'h0, cfg}, 1'b0);
		apb(1'b1, `DTW_OFF_WINDOW, {24'h0, cnt}, 1'b0);
		openWin();
		ticks = 0;
		seen = 1'b0;
		for (int n = 0; n < 4 || seen; n++)
		begin
			@(posedge mclk);
			if (windowOpen === 1'b1 && baseTick === 1'b1) ticks++;
			if (seen && windowOpen !== 1'b1) break;
			seen |= windowOpen === 1'b1;
		end
		repeat (3) @(posedge mclk);
		chk("ticks", ticks, exp);
		chk("irq", {31'h0, irq}, {31'h0, maskVal[1]});
		rdChk(`DTW_OFF_STATUS, 32'h2, 1'b0);
		rdChk(`DTW_OFF_STATUS, 32'h0, 1'b0);
		chk("irq", {31'h0, irq}, 32'h0);
	endtask
	task doPulse(input logic [7:0] lim, input int dl, input logic [31:0] st, input int dp);
		int d0;
		d0 = dpCount;
		pulseTimeLimit <= lim;
		apb(1'b1, `DTW_OFF_CONFIG, 32'h41, 1'b0);
		apb(1'b1, `DTW_OFF_WINDOW, 32'h2, 1'b0);
		openWin();
		repeat (dl) @(posedge mclk);
		pulseAbove <= 1'b1;
		repeat (2)
		begin
			repeat (4) @(posedge mclk);
			limitTick <= 1'b1;
			@(posedge mclk);
			limitTick <= 1'b0;
		end
		// pulse outlasts the window end on purpose
		repeat (40) @(posedge mclk);
		pulseAbove <= 1'b0;
		repeat (3) @(posedge mclk);
		chk("double", dpCount - d0, dp);
		rdChk(`DTW_OFF_STATUS, st, 1'b0);
	endtask
	// ----
	// main sequence
	// ----
	initial
	begin
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		for (int i = 0; i < 6; i++) rdChk(addrs[i], exps[i], i == 5);
		apb(1'b1, `DTW_OFF_MASK, 32'hFF, 1'b0);
		rdChk(`DTW_OFF_MASK, 32'h7, 1'b0);
		apb(1'b1, `DTW_OFF_WINDOW, 32'hFFFFFFAB, 1'b0);
		rdChk(`DTW_OFF_WINDOW, 32'hAB, 1'b0);
		for (int m = 0; m < 4; m++)
			for (int r = 0; r < 8; r++)
				doWin({2'h1, m[1:0], r[2:0], 1'b1}, 8'h01, stepFor(r, m, 1, 0));
		doWin(8'hC1, 8'h03, 3 * stepFor(0, 0, 1, 1));
		doWin(8'h41, 8'hFF, 255 * stepFor(0, 0, 1, 0));
		doWin(8'h03, 8'h02, 2 * stepFor(1, 0, 0, 0));
		maskVal = 3'h0;
		apb(1'b1, `DTW_OFF_MASK, 32'h0, 1'b0);
		doWin(8'h41, 8'h00, 0);
		doPulse(8'h04, 4, 32'h1, 1);
		doPulse(8'h03, 4, 32'h1, 1);
		doPulse(8'h02, 4, 32'h4, 0);
		// start after the window has expired: only the expiry is reported
		doPulse(8'h04, 40, 32'h2, 0);
		end_of_test();
	end
endmodule // tb_double_tap_window_timer
